// ### bench/scc_chk_asserts.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// port checks of the serial channel
// ----------------------------------------------------------------
module scc_chk (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk,
    input wire logic        rxd,
    input wire logic        txd
);
    logic wr2_acc;
    logic armed_reg;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // write access to mode two register
    assign wr2_acc = psel && penable && pwrite && pready && (paddr == 12'h004);
    // first key half seen, any other mode two write disarms
    always @(posedge ref_clk) begin
        if (rst)
            armed_reg <= 1'b0;
        else if (wr2_acc)
            armed_reg <= (pwdata[1:0] == 2'h2);
    end
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence key_fire;
        wr2_acc && armed_reg && (pwdata[1:0] == 2'h1);
    endsequence
    setup_ready_a: assert property (apb_setup |=> pready)
        else $error("setup not answered next cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    resv_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");
    unmapped_err_a: assert property (pready && paddr > 12'h010 |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr <= 12'h010 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    rst_idle_a: assert property ($fell(rst) |-> txd && !pready)
        else $error("outputs not idle after reset");
    soft_rst_a: assert property (key_fire |-> ##3 txd [*4])
        else $error("line not idle after soft reset");
endmodule
bind scc_channel scc_chk u_chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .rxd(rxd), .txd(txd)
);

// ### bench/scc_peer.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// serial peer on the link side
// ----------------------------------------------------------------
module scc_peer (
    output logic      sclk,
    output logic      rxd,
    input  wire logic txd
);
    // clock parked high and line idle high between frames
    initial begin
        sclk = 1'b1;
        rxd  = 1'b1;
    end
    // one bit per 80 ns: data out on fall, line taken on rise
    task automatic xfer(input logic [11:0] send, input int n, output logic [11:0] got);
        int i;
        got = 12'h000;
        #3;
        for (i = 0; i < n; i++) begin
            sclk = 1'b0;
            rxd  = send[i];
            #40;
            sclk = 1'b1;
            got[i] = txd;
            #40;
        end
        rxd = 1'b1;
    endtask
endmodule

// ### bench/tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// bench top
// ----------------------------------------------------------------
module tb;
    logic        ref_clk     = 1'b0;
    logic        rst         = 1'b1;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0000_0000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         sclk;
    wire         rxd;
    wire         txd;
    int          n_fail      = 0;
    int          checks_done = 0;
    int          cycles      = 0;
    logic [31:0] rd;
    logic        err;
    logic [11:0] got;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    scc_channel #(.DATA_W(8)) dut (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclk(sclk), .rxd(rxd), .txd(txd)
    );
    scc_peer peer (.sclk(sclk), .rxd(rxd), .txd(txd));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    // reset values, read-only bits, unmapped place
    task automatic t_regs();
        rdc("mode2 reset", 12'h004, 32'h0000_0080);
        wr(12'h004, 32'hFFFF_FFFC);
        rdc("mode2 ro", 12'h004, 32'h0000_009C);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("t_regs done");
    endtask
    // uart frame both ways, two stop bits, then key twice mid-send
    task automatic t_uart();
        wr(12'h000, 32'h0000_000B);
        wr(12'h004, 32'h0000_001C);
        wr(12'h008, 32'h0000_00A5);
        rdc("moved", 12'h004, 32'h0000_00BC);
        wr(12'h008, 32'h0000_003C);
        rdc("refill", 12'h004, 32'h0000_003C);
        peer.xfer({3'b111, 8'h5A, 1'b0}, 12, got);
        chk("uart frame", {21'h0, got[10:0]}, 32'h0000_074A);
        rdc("after frame", 12'h004, 32'h0000_00FC);
        rdc("rx byte", 12'h00C, 32'h0000_005A);
        peer.xfer(12'h0B4, 10, got);
        chk("uart frame2", {22'h0, got[9:0]}, 32'h0000_0278);
        rdc("framing", 12'h010, 32'h0000_0004);
        repeat (2) begin
            wr(12'h004, 32'h0000_001E);
            wr(12'h004, 32'h0000_001D);
        end
        repeat (3) @(posedge ref_clk);
        rdc("swr mode2", 12'h004, 32'h0000_001D);
        rdc("swr mode0", 12'h000, 32'h0000_0008);
        rdc("swr err", 12'h010, 32'h0000_0000);
        $display("t_uart done");
    endtask
    // clocked mode, msb first
    task automatic t_io();
        wr(12'h000, 32'h0000_0003);
        wr(12'h004, 32'h0000_0008);
        wr(12'h008, 32'h0000_0096);
        peer.xfer(12'h1B4, 9, got);
        chk("io tx", {24'h0, got[7:0]}, 32'h0000_0069);
        rdc("io rx", 12'h00C, 32'h0000_002D);
        $display("t_io done");
    endtask
    // wrong keys ignored, other registers do not disarm
    task automatic t_key();
        wr(12'h004, 32'h0000_000A);
        wr(12'h004, 32'h0000_000B);
        wr(12'h004, 32'h0000_0009);
        repeat (3) @(posedge ref_clk);
        rdc("bad key", 12'h000, 32'h0000_0003);
        wr(12'h004, 32'h0000_000A);
        wr(12'h008, 32'h0000_0011);
        wr(12'h004, 32'h0000_0009);
        repeat (3) @(posedge ref_clk);
        rdc("key ok", 12'h000, 32'h0000_0000);
        wr(12'h008, 32'h0000_0055);
        rdc("tx held", 12'h004, 32'h0000_0009);
        $display("t_key done");
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_uart();
        t_io();
        t_key();
        results();
    end
endmodule

// ### core/scc_channel.v
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "scc_consts.vh"
// serial channel with mode control two register behind apb
module scc_channel #(
    parameter DATA_W = 8
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        sclk,
    input  wire        rxd,
    output reg         txd
);
    // ----------------------------------------------------------------
    // state encodings
    // ----------------------------------------------------------------
    localparam TX_IDLE  = 4'h1;
    localparam TX_START = 4'h2;
    localparam TX_DATA  = 4'h4;
    localparam TX_STOP  = 4'h8;
    localparam RX_IDLE  = 3'h1;
    localparam RX_DATA  = 3'h2;
    localparam RX_STOP  = 3'h4;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    wire [1:0]        pin_sync;
    wire              sclk_s;
    wire              rxd_s;
    reg               sclk_prev_reg;
    wire              sclk_rise;
    wire              sclk_fall;
    reg               rx_en_reg;
    reg               tx_en_reg;
    reg  [1:0]        sm_reg;
    reg               stop_bit_length_sel_reg;
    reg               order_reg;
    reg               double_buffer_enable_reg;
    reg  [1:0]        key_reg;
    reg               key_armed_reg;
    reg  [`SCC_SWR_DELAY-1:0] swr_pipe_reg;
    wire              soft_rst;
    reg               tbemp_reg;
    reg               rbfll_reg;
    reg               txrun_reg;
    reg               oerr_reg;
    reg               perr_reg;
    reg               ferr_reg;
    reg  [DATA_W-1:0] tx_buf_reg;
    reg               tx_buf_full_reg;
    reg  [DATA_W-1:0] tx_sh_reg;
    reg  [3:0]        tx_state_reg;
    reg  [3:0]        tx_cnt_reg;
    reg               tx_stop_left_reg;
    reg  [DATA_W-1:0] rx_sh_reg;
    reg  [DATA_W-1:0] rx_buf_reg;
    reg  [2:0]        rx_state_reg;
    reg  [3:0]        rx_cnt_reg;
    wire              uart_mode;
    wire              msb_first;
    wire              setup_ph;
    wire              access_ph;
    wire              wr_acc;
    wire              rd_acc;
    wire              tx_wr;
    wire              tx_wr_ok;
    wire              tx_load;
    reg               rx_done;
    reg  [DATA_W-1:0] rx_word;
    reg               rx_stop_bad_reg;
    reg  [31:0]       rd_mux;
    reg               rd_hit;

    // bit reversal for msb-first transfers
    function [DATA_W-1:0] flip;
        input [DATA_W-1:0] d;
        integer i;
        begin
            for (i = 0; i < DATA_W; i = i + 1) begin
                flip[i] = d[DATA_W-1-i];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisation and link clock edges
    // ----------------------------------------------------------------
    scc_sync2 #(.WIDTH(2)) u_pin_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({sclk, rxd}),
        .sync_out (pin_sync)
    );

    assign sclk_s = pin_sync[1];
    assign rxd_s  = pin_sync[0];

    // previous link clock level for edge finding
    always @(posedge ref_clk) begin
        if (rst) begin
            sclk_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_s & sclk_prev_reg;
    assign uart_mode = (sm_reg != `SCC_SM_IO);
    assign msb_first = order_reg & ~uart_mode;               // [R8] [R16]

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & pready;
    assign wr_acc    = access_ph & pwrite & ~pslverr;
    assign rd_acc    = access_ph & ~pwrite & ~pslverr;
    assign tx_wr     = wr_acc & (paddr == `SCC_OFS_TXDATA);
    // single buffer takes a write only while shifter and buffer are idle
    assign tx_wr_ok  = tx_wr & (double_buffer_enable_reg | (~txrun_reg & ~tx_buf_full_reg)); // [R9]
    assign tx_load   = (tx_state_reg == TX_IDLE) & tx_en_reg & tx_buf_full_reg; // [R15]

    // read multiplexer, reserved bits read zero
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr)
            `SCC_OFS_MODE0: begin
                rd_mux[`SCC_M0_RXE] = rx_en_reg;
                rd_mux[`SCC_M0_TXE] = tx_en_reg;
                rd_mux[`SCC_M0_SM_HI:`SCC_M0_SM_LO] = sm_reg;
            end
            `SCC_OFS_MODE2: begin
                rd_mux[`SCC_M2_TBEMP] = tbemp_reg;
                rd_mux[`SCC_M2_RBFLL] = rbfll_reg;                // [R4]
                rd_mux[`SCC_M2_TXRUN] = txrun_reg;                // [R5] [R6]
                rd_mux[`SCC_M2_STOP_BIT_LENGTH_SEL] = stop_bit_length_sel_reg;
                rd_mux[`SCC_M2_ORDER] = order_reg;
                rd_mux[`SCC_M2_DOUBLE_BUFFER_ENABLE]  = double_buffer_enable_reg;
                rd_mux[`SCC_M2_KEY_HI:`SCC_M2_KEY_LO] = key_reg;  // [R18]
            end
            `SCC_OFS_TXDATA: rd_mux = 32'h0000_0000;
            `SCC_OFS_RXDATA: rd_mux[DATA_W-1:0] = rx_buf_reg;
            `SCC_OFS_ERR: begin
                rd_mux[`SCC_ERR_OERR] = oerr_reg;
                rd_mux[`SCC_ERR_PERR] = perr_reg;
                rd_mux[`SCC_ERR_FERR] = ferr_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // one wait-free answer: ready raised in setup, held through access
    always @(posedge ref_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~rd_hit;
            if (setup_ph & ~pwrite) begin
                prdata <= rd_mux;
            end else if (access_ph) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // control registers and soft reset key
    // ----------------------------------------------------------------
    assign soft_rst = swr_pipe_reg[`SCC_SWR_DELAY-1];

    // key recognition and two-clock delay before execution
    always @(posedge ref_clk) begin
        if (rst) begin
            key_reg       <= 2'h0;
            key_armed_reg <= 1'b0;
            swr_pipe_reg  <= {`SCC_SWR_DELAY{1'b0}};
        end else begin
            swr_pipe_reg <= {swr_pipe_reg[`SCC_SWR_DELAY-2:0], 1'b0};   // [R14]
            if (wr_acc & (paddr == `SCC_OFS_MODE2)) begin
                key_reg <= pwdata[`SCC_M2_KEY_HI:`SCC_M2_KEY_LO];
                if (pwdata[`SCC_M2_KEY_HI:`SCC_M2_KEY_LO] == `SCC_KEY_FIRST) begin
                    key_armed_reg <= 1'b1;                                // [R11]
                end else begin
                    key_armed_reg <= 1'b0;                                // [R17]
                    if (key_armed_reg &&
                        pwdata[`SCC_M2_KEY_HI:`SCC_M2_KEY_LO] == `SCC_KEY_SECOND) begin
                        swr_pipe_reg[0] <= 1'b1;                          // [R11]
                    end
                end
            end
        end
    end

    // writable control bits; flags stay out of reach of writes
    always @(posedge ref_clk) begin
        if (rst) begin
            rx_en_reg <= 1'b0;
            tx_en_reg <= 1'b0;
            sm_reg    <= 2'h0;
            stop_bit_length_sel_reg <= 1'b0;
            order_reg <= 1'b0;
            double_buffer_enable_reg  <= 1'b0;
        end else if (soft_rst) begin
            rx_en_reg <= 1'b0;                                            // [R12]
            tx_en_reg <= 1'b0;                                            // [R12]
        end else if (wr_acc & (paddr == `SCC_OFS_MODE0)) begin
            rx_en_reg <= pwdata[`SCC_M0_RXE];
            tx_en_reg <= pwdata[`SCC_M0_TXE];
            sm_reg    <= pwdata[`SCC_M0_SM_HI:`SCC_M0_SM_LO];
        end else if (wr_acc & (paddr == `SCC_OFS_MODE2)) begin
            stop_bit_length_sel_reg <= pwdata[`SCC_M2_STOP_BIT_LENGTH_SEL];
            order_reg <= pwdata[`SCC_M2_ORDER];
            double_buffer_enable_reg  <= pwdata[`SCC_M2_DOUBLE_BUFFER_ENABLE];                            // [R18]
        end
    end

    // ----------------------------------------------------------------
    // transmit buffer and empty flag
    // ----------------------------------------------------------------
    // a write in the same cycle as a move keeps the new data pending
    always @(posedge ref_clk) begin
        if (rst) begin
            tx_buf_reg      <= {DATA_W{1'b0}};
            tx_buf_full_reg <= 1'b0;
            tbemp_reg       <= `SCC_TBEMP_RST;
        end else if (soft_rst) begin
            tx_buf_full_reg <= 1'b0;
            tbemp_reg       <= 1'b0;                                      // [R12]
        end else if (tx_wr_ok) begin
            tx_buf_reg      <= pwdata[DATA_W-1:0];
            tx_buf_full_reg <= 1'b1;
            tbemp_reg       <= 1'b0;                                      // [R2] [R3]
        end else if (tx_load) begin
            tx_buf_full_reg <= 1'b0;
            tbemp_reg       <= 1'b1;                                      // [R1]
        end
    end

    // ----------------------------------------------------------------
    // transmit engine, shifts on falling link clock edges
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst | soft_rst) begin
            tx_state_reg     <= TX_IDLE;
            tx_sh_reg        <= {DATA_W{1'b0}};
            tx_cnt_reg       <= 4'h0;
            tx_stop_left_reg <= 1'b0;
            txrun_reg        <= 1'b0;                                     // [R12]
            txd              <= 1'b1;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg    <= msb_first ? flip(tx_buf_reg) : tx_buf_reg; // [R8]
                        tx_cnt_reg   <= 4'h0;
                        txrun_reg    <= 1'b1;                             // [R5]
                        tx_state_reg <= uart_mode ? TX_START : TX_DATA;
                    end
                end
                TX_START: begin
                    if (sclk_fall) begin
                        txd          <= 1'b0;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (sclk_fall) begin
                        if (tx_cnt_reg == `SCC_DATA_BITS) begin
                            txd <= 1'b1;
                            if (uart_mode) begin
                                tx_stop_left_reg <= stop_bit_length_sel_reg;            // [R7]
                                tx_state_reg     <= TX_STOP;
                            end else begin
                                txrun_reg    <= 1'b0;
                                tx_state_reg <= TX_IDLE;
                            end
                        end else begin
                            txd        <= tx_sh_reg[0];
                            tx_sh_reg  <= {1'b0, tx_sh_reg[DATA_W-1:1]};
                            tx_cnt_reg <= tx_cnt_reg + 4'h1;
                        end
                    end
                end
                TX_STOP: begin
                    if (sclk_fall) begin
                        if (tx_stop_left_reg) begin
                            tx_stop_left_reg <= 1'b0;
                        end else begin
                            txrun_reg    <= 1'b0;                         // [R6]
                            tx_state_reg <= TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                    txrun_reg    <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // receive engine, samples on rising link clock edges
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rst | soft_rst) begin
            rx_state_reg <= RX_IDLE;
            rx_sh_reg    <= {DATA_W{1'b0}};
            rx_cnt_reg   <= 4'h0;
            rx_done      <= 1'b0;
            rx_word      <= {DATA_W{1'b0}};
            rx_stop_bad_reg <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            rx_stop_bad_reg <= 1'b0;
            case (rx_state_reg)
                RX_IDLE: begin
                    if (sclk_rise & rx_en_reg) begin
                        if (~uart_mode) begin
                            rx_sh_reg    <= {rxd_s, rx_sh_reg[DATA_W-1:1]};
                            rx_cnt_reg   <= 4'h1;
                            rx_state_reg <= RX_DATA;
                        end else if (~rxd_s) begin
                            rx_cnt_reg   <= 4'h0;
                            rx_state_reg <= RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (sclk_rise) begin
                        rx_sh_reg  <= {rxd_s, rx_sh_reg[DATA_W-1:1]};
                        rx_cnt_reg <= rx_cnt_reg + 4'h1;
                        if (rx_cnt_reg == `SCC_DATA_BITS - 4'h1) begin
                            if (uart_mode) begin
                                rx_state_reg <= RX_STOP;
                            end else begin
                                rx_word      <= msb_first ?
                                                flip({rxd_s, rx_sh_reg[DATA_W-1:1]}) :
                                                {rxd_s, rx_sh_reg[DATA_W-1:1]}; // [R8]
                                rx_done      <= 1'b1;
                                rx_state_reg <= RX_IDLE;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    // exactly one stop bit is checked on reception
                    if (sclk_rise) begin
                        rx_word      <= rx_sh_reg;                        // [R7] [R16]
                        rx_stop_bad_reg <= ~rxd_s;                        // [R7]
                        rx_done      <= 1'b1;
                        rx_state_reg <= RX_IDLE;
                    end
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // receive buffer, full flag and errors; set wins over clear
    always @(posedge ref_clk) begin
        if (rst | soft_rst) begin
            rx_buf_reg <= {DATA_W{1'b0}};
            rbfll_reg  <= 1'b0;                                           // [R12]
            oerr_reg   <= 1'b0;
            perr_reg   <= 1'b0;
            ferr_reg   <= 1'b0;
        end else begin
            if (rd_acc & (paddr == `SCC_OFS_RXDATA)) begin
                rbfll_reg <= 1'b0;
            end
            if (wr_acc & (paddr == `SCC_OFS_ERR)) begin
                oerr_reg <= oerr_reg & ~pwdata[`SCC_ERR_OERR];
                perr_reg <= perr_reg & ~pwdata[`SCC_ERR_PERR];
                ferr_reg <= ferr_reg & ~pwdata[`SCC_ERR_FERR];
            end
            if (rx_done) begin
                if (rbfll_reg & ~(rd_acc & (paddr == `SCC_OFS_RXDATA))) begin
                    oerr_reg <= 1'b1;
                end else begin
                    rx_buf_reg <= rx_word;                                // [R10]
                end
                rbfll_reg <= 1'b1;                                        // [R4]
                if (rx_stop_bad_reg) begin
                    ferr_reg <= 1'b1;
                end
            end
        end
    end
endmodule

// ### core/scc_consts.vh
// Summary of operation
// [R1] buffer-to-shifter move sets transmit empty flag
// [R2] writing transmit data clears the empty flag
// [R3] empty flag meaningless without double buffering
// [R4] receive full flag read-only at bit 6
// [R5] transmit running flag read-only at bit 5
// [R6] running and empty flags combine into status
// [R7] stop-bit control sets transmit stop length only
// [R8] bit 3 picks lsb-first or msb-first order
// [R9] bit 2 enables transmit double buffering
// [R10] receive always double buffered
// [R11] key write 10 then 01 requests reset
// [R12] soft reset clears enables, flags, errors, engines
// [R13] busy transmitter needs key sequence twice; code resets on the first sequence even while transmit is running
// [R14] soft reset executes two clocks after recognition
// [R15] transmit enable gates every transmission start
// [R16] uart modes always send lsb first
// [R17] any other key write restarts recognition
// [R18] read-only and reserved bits ignore writes, read zero
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCC_OFS_MODE0   12'h000
`define SCC_OFS_MODE2   12'h004
`define SCC_OFS_TXDATA  12'h008
`define SCC_OFS_RXDATA  12'h00C
`define SCC_OFS_ERR     12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCC_M0_RXE      0
`define SCC_M0_TXE      1
`define SCC_M0_SM_LO    2
`define SCC_M0_SM_HI    3
`define SCC_M2_TBEMP    7
`define SCC_M2_RBFLL    6
`define SCC_M2_TXRUN    5
`define SCC_M2_STOP_BIT_LENGTH_SEL    4
`define SCC_M2_ORDER    3
`define SCC_M2_DOUBLE_BUFFER_ENABLE     2
`define SCC_M2_KEY_HI   1
`define SCC_M2_KEY_LO   0
`define SCC_ERR_OERR    0
`define SCC_ERR_PERR    1
`define SCC_ERR_FERR    2

// ----------------------------------------------------------------
// reset values, key codes, timing
// ----------------------------------------------------------------
`define SCC_TBEMP_RST   1'b1
`define SCC_KEY_FIRST   2'h2
`define SCC_KEY_SECOND  2'h1
`define SCC_SM_IO       2'h0
`define SCC_SWR_DELAY   2
`define SCC_DATA_BITS   4'h8

`endif

// ### core/scc_sync2.v
`timescale 1ns/10ps
// two-stage synchroniser for levels from outside the clock domain
module scc_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;

    // first stage feeds only the second stage
    always @(posedge ref_clk) begin
        if (rst) begin
            stage1_reg <= {WIDTH{1'b1}};
            stage2_reg <= {WIDTH{1'b1}};
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;
endmodule
